// ===== common/mvp_pkg.sv
package mvp_pkg;
    // ****************************************
    // register map, byte addresses on the bus
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_ABS_LO = 8'h08;
    localparam logic [7:0] ADDR_ABS_HI = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RTC_LO = 8'h14;
    localparam logic [7:0] ADDR_RTC_HI = 8'h18;
    localparam logic [7:0] ADDR_SCR_LO = 8'h1c;
    localparam logic [7:0] ADDR_SCR_HI = 8'h20;
    localparam logic [7:0] ADDR_LAST_CW = 8'h24;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_IPH_EN = 1;
    localparam int CTRL_SCR_EN = 2;
    localparam int CTRL_ABS_TIME = 6;
    localparam int CTRL_FMT_LO = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ****************************************
    // channel word fields
    // ****************************************
    localparam int CW_RSVD_LO = 22;
    localparam int CW_KLV = 21;
    localparam int CW_SRS = 20;
    localparam int CW_IPH = 19;
    localparam int CW_EPL_HI = 18;
    localparam int CW_EPL_LO = 15;
    localparam int CW_ET = 14;
    localparam int CW_MD = 13;
    localparam int CW_TP = 12;
    localparam int CW_PC_HI = 11;
    localparam logic [3:0] EPL_MAX = 4'hb;
    localparam logic [11:0] PC_UNKNOWN = 12'h000;

    // ****************************************
    // clock reference constants
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int MPEG_HZ = 27_000_000;
    // 27 MHz from 10 MHz: 2.7 ticks per cycle, kept as a fraction of 10
    localparam logic [4:0] MPEG_NUM = 5'(MPEG_HZ / (CLK_HZ / 10));
    localparam logic [4:0] MPEG_DEN = 5'h0a;
    localparam logic [8:0] EXT_MOD = 9'h12c;  // 300 ticks per base step
    localparam int BASE_W = 33;
    localparam int EXT_W = 9;
    localparam int RTC_W = 48;

    // ****************************************
    // framer states and output word kinds
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HDR = 6'b000010,
        ST_CW = 6'b000100,
        ST_TS_LO = 6'b001000,
        ST_TS_HI = 6'b010000,
        ST_DATA = 6'b100000
    } mvp_state_t;

    typedef enum logic [2:0] {
        KIND_HDR = 3'h0,
        KIND_CW = 3'h1,
        KIND_TS = 3'h2,
        KIND_DATA = 3'h3,
        KIND_TRL = 3'h4
    } mvp_kind_t;
endpackage

// ===== core/mvp_packetizer.sv
// How it works
// - header, word, stamped packets, then back to idle with no trailer word
// - top ten channel word bits reserved
// - bit 21 flags metadata presence
// - bit 20 flags clock reference sync
// - 27 MHz tick slaved to 10 MHz
// - reference is base times 300 plus extension
// - extension ticks mod 300, base wraps
// - bit 19 flags intra packet stamps
// - profile level codes up to 1011
// - bit 14 flags embedded time
// - bit 13 constant or variable rate
// - bit 12 transport or program stream
// - bits 11-0 count packets or packs
// - unknown count written as zero
// - only whole packets per video packet
// - stamp low word then high word
// - relative stamp 48 bits, top zero
// - absolute stamp when flag bit 6
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mvp_packetizer
    import mvp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // encoder stream, 32-bit words, last marks end of an mpeg packet or pack
    input wire logic [31:0] enc_data,
    input wire logic enc_valid,
    input wire logic enc_last,
    output logic enc_ready,
    // encoder side flags for the channel word
    input wire logic enc_klv,
    input wire logic enc_embedded_time,
    input wire logic enc_count_known,
    // recording stream out
    output logic [31:0] rec_data,
    output logic [2:0] rec_kind,
    output logic rec_valid,
    input wire logic rec_ready
);

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl;
    logic [31:0] config_word;
    logic [31:0] abs_lo;
    logic [31:0] abs_hi;
    logic [RTC_W-1:0] rtc;
    logic [4:0] frac;
    logic [BASE_W-1:0] scr_base;
    logic [EXT_W-1:0] scr_ext;
    logic [31:0] last_cw;
    logic [11:0] pkt_cnt;
    logic [11:0] per_packet;
    logic [RTC_W-1:0] stamp_rtc;
    mvp_state_t state;

    // config fields: profile level, rate, type, packets per video packet
    logic [3:0] cfg_epl;
    logic cfg_vbr;
    logic cfg_prog;
    assign cfg_epl = (config_word[3:0] > EPL_MAX) ? EPL_MAX : config_word[3:0];
    assign cfg_vbr = config_word[4];
    assign cfg_prog = config_word[5];
    assign per_packet = (config_word[27:16] == 12'h000) ? 12'h001 : config_word[27:16];

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // address and data accepted in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= ADDR_ABS_HI) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            config_word <= 32'h0000_0000;
            abs_lo <= 32'h0000_0000;
            abs_hi <= 32'h0000_0000;
        end else if (wr_fire) begin
            case (aw_addr)
                ADDR_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
                ADDR_CONFIG: config_word <= merge(config_word, w_data, w_strb);
                ADDR_ABS_LO: abs_lo <= merge(abs_lo, w_data, w_strb);
                ADDR_ABS_HI: abs_hi <= merge(abs_hi, w_data, w_strb);
                default: ;
            endcase
        end
    end

    // read channel, answer two cycles after arvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    ADDR_CTRL: s_axi_rdata <= ctrl;
                    ADDR_CONFIG: s_axi_rdata <= config_word;
                    ADDR_ABS_LO: s_axi_rdata <= abs_lo;
                    ADDR_ABS_HI: s_axi_rdata <= abs_hi;
                    ADDR_STATUS: s_axi_rdata <= {20'h00000, pkt_cnt};
                    ADDR_RTC_LO: s_axi_rdata <= rtc[31:0];
                    ADDR_RTC_HI: s_axi_rdata <= {16'h0000, rtc[47:32]};
                    ADDR_SCR_LO: s_axi_rdata <= scr_base[31:0];
                    ADDR_SCR_HI: s_axi_rdata <= {scr_ext, 22'h000000, scr_base[32]};
                    ADDR_LAST_CW: s_axi_rdata <= last_cw;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // time bases
    // ****************************************
    // free-running 10 MHz real-time clock, one tick per aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc <= 48'h0000_0000_0000;
        end else begin
            rtc <= rtc + 48'h0000_0000_0001;
        end
    end

    // 27 MHz ticks slaved to the rtc: add 27 tenths per cycle, so 2 or 3
    // ticks land each cycle and none drift over the long run
    // one bit wider than frac: frac plus 27 reaches 36 and must not wrap
    logic [5:0] sum;
    logic [1:0] ticks;
    logic [9:0] ext_sum;
    assign sum = {1'b0, frac} + {1'b0, MPEG_NUM};
    assign ticks = (sum >= 6'(3 * MPEG_DEN)) ? 2'h3 : 2'h2;
    assign ext_sum = {1'b0, scr_ext} + {8'h00, ticks};

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl[CTRL_SCR_EN]) begin
            frac <= 5'h00;
            scr_base <= 33'h0_0000_0000;
            scr_ext <= 9'h000;
        end else begin
            frac <= 5'(sum - 6'(MPEG_DEN) * {4'h0, ticks});
            // extension counts ticks mod 300; base carries and wraps at 33 bits
            if (ext_sum >= {1'b0, EXT_MOD}) begin
                scr_ext <= 9'(ext_sum - {1'b0, EXT_MOD});
                scr_base <= scr_base + 33'h0_0000_0001;
            end else begin
                scr_ext <= ext_sum[8:0];
            end
        end
    end

    // ****************************************
    // channel word
    // ****************************************
    logic [31:0] next_cw;
    always_comb begin
        next_cw = 32'h0000_0000;  // reserved bits stay zero
        next_cw[CW_KLV] = enc_klv;
        next_cw[CW_SRS] = ctrl[CTRL_SCR_EN];
        next_cw[CW_IPH] = ctrl[CTRL_IPH_EN];
        next_cw[CW_EPL_HI:CW_EPL_LO] = cfg_epl;
        next_cw[CW_ET] = enc_embedded_time;
        next_cw[CW_MD] = cfg_vbr;
        next_cw[CW_TP] = cfg_prog;
        // count of packets or packs, zero when the encoder cannot tell
        next_cw[CW_PC_HI:0] = enc_count_known ? per_packet : PC_UNKNOWN;
    end

    // ****************************************
    // framer
    // ****************************************
    logic out_free;
    assign out_free = !rec_valid || rec_ready;

    // stamp value: relative rtc with top 16 bits zero, or absolute time
    logic [63:0] stamp;
    // low word from the live rtc, high word from the copy taken with it, so a
    // carry out of the low word between the two cycles cannot tear the stamp
    assign stamp = ctrl[CTRL_ABS_TIME] ? {abs_hi, abs_lo}
        : {16'h0000, stamp_rtc[RTC_W-1:32], rtc[31:0]};

    // encoder words pass only inside the data state and when output is free
    assign enc_ready = (state == ST_DATA) && out_free;

    // sequence: header, channel word, then per packet stamp and data; the
    // frame returns to idle only after a last word, so packets never split
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            rec_valid <= 1'b0;
            rec_data <= 32'h0000_0000;
            rec_kind <= KIND_HDR;
            pkt_cnt <= 12'h000;
            last_cw <= 32'h0000_0000;
            stamp_rtc <= 48'h0000_0000_0000;
        end else begin
            if (rec_valid && rec_ready) rec_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (ctrl[CTRL_ENABLE] && enc_valid && out_free) begin
                        state <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (out_free) begin
                        rec_valid <= 1'b1;
                        rec_kind <= KIND_HDR;
                        rec_data <= 32'h0000_0000;
                        state <= ST_CW;
                    end
                end
                ST_CW: begin
                    if (out_free) begin
                        rec_valid <= 1'b1;
                        rec_kind <= KIND_CW;
                        rec_data <= next_cw;
                        last_cw <= next_cw;
                        pkt_cnt <= 12'h000;
                        state <= ctrl[CTRL_IPH_EN] ? ST_TS_LO : ST_DATA;
                    end
                end
                ST_TS_LO: begin
                    if (out_free) begin
                        rec_valid <= 1'b1;
                        rec_kind <= KIND_TS;
                        rec_data <= stamp[31:0];  // low word first
                        stamp_rtc <= rtc;  // high word comes from this same instant
                        state <= ST_TS_HI;
                    end
                end
                ST_TS_HI: begin
                    if (out_free) begin
                        rec_valid <= 1'b1;
                        rec_kind <= KIND_TS;
                        rec_data <= stamp[63:32];  // high word right after
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (enc_valid && out_free) begin
                        rec_valid <= 1'b1;
                        rec_data <= enc_data;
                        if (enc_last) begin
                            pkt_cnt <= pkt_cnt + 12'h001;
                            if (pkt_cnt + 12'h001 >= per_packet) begin
                                state <= ST_IDLE;
                            end else if (ctrl[CTRL_IPH_EN]) begin
                                state <= ST_TS_LO;
                            end
                        end
                        rec_kind <= KIND_DATA;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // mvp_packetizer
`default_nettype wire

// ===== tb/mvp_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module mvp_checker
    import mvp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // streams
    input wire logic [31:0] enc_data,
    input wire logic enc_valid,
    input wire logic enc_ready,
    input wire logic enc_klv,
    input wire logic enc_embedded_time,
    input wire logic enc_count_known,
    input wire logic [31:0] rec_data,
    input wire logic [2:0] rec_kind,
    input wire logic rec_valid,
    input wire logic rec_ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] last_kind;
    logic cw_out;
    assign cw_out = rec_valid && rec_kind == KIND_CW;
    // kind of the last word the sink took
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_kind <= KIND_DATA;
        end else if (rec_valid && rec_ready) begin
            last_kind <= rec_kind;
        end
    end
    a_rsvd_zero: assert property (cw_out |-> rec_data[31:22] == 10'h0)
        else $error("reserved channel word bits set");
    a_epl_range: assert property (cw_out |-> rec_data[18:15] <= EPL_MAX)
        else $error("reserved profile level code");
    a_flag_copy: assert property (cw_out |-> rec_data[21] == enc_klv
        && rec_data[14] == enc_embedded_time) else $error("flag bits wrong");
    a_count_zero: assert property (cw_out && !enc_count_known |-> rec_data[11:0] == PC_UNKNOWN)
        else $error("unknown count not zero");
    a_cw_follows: assert property (rec_valid && rec_ready && rec_kind == KIND_CW
        |-> last_kind == KIND_HDR) else $error("channel word not after header");
    a_data_pass: assert property (enc_valid && enc_ready |=> rec_valid
        && rec_kind == KIND_DATA && rec_data == $past(enc_data)) else $error("data word lost");
    a_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid
        && $stable(rec_data) && $stable(rec_kind)) else $error("output dropped while stalled");
    a_read_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule // mvp_checker
bind mvp_packetizer mvp_checker chk_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_rvalid,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .enc_data, .enc_valid, .enc_ready, .enc_klv,
    .enc_embedded_time, .enc_count_known, .rec_data, .rec_kind, .rec_valid, .rec_ready);
`default_nettype wire

// ===== tb/mvp_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// encoder model: whole packets, word 0 carries the sync byte
// ****
module mvp_enc_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench control
    input wire logic start,
    input wire logic [3:0] pkts,
    input wire logic [3:0] len,
    input wire logic slow,
    // stream toward the framer
    output logic [31:0] enc_data,
    output logic enc_valid,
    output logic enc_last,
    input wire logic enc_ready
);
    logic [3:0] left;
    logic [3:0] w;
    logic gap;
    logic [3:0] rem;
    logic offer;
    // packets still owed after this edge
    assign rem = start ? pkts : left - {3'h0, enc_valid && enc_ready && enc_last};
    assign offer = rem != 4'h0 && !(slow && !gap);
    // a word is held until taken; an idle line shows the inverse, not stale data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left <= 4'h0;
            w <= 4'h0;
            gap <= 1'b0;
            enc_valid <= 1'b0;
            enc_last <= 1'b0;
            enc_data <= 32'h0;
        end else begin
            left <= rem;
            if (!enc_valid || enc_ready) begin
                gap <= slow && !gap;
                enc_valid <= offer;
                if (offer) begin
                    enc_data <= (w == 4'h0) ? 32'h4700_0000 : {16'h0da7, 12'h0, w};
                    enc_last <= w == len - 4'h1;
                    w <= (w == len - 4'h1) ? 4'h0 : w + 4'h1;
                end else begin
                    enc_data <= ~enc_data;
                end
            end
        end
    end
endmodule // mvp_enc_model
`default_nettype wire

// ===== tb/mvp_packetizer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mvp_packetizer_bench import mvp_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, enc_valid, enc_last, enc_ready, rec_valid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, enc_data, rec_data, d, h;
    logic [2:0] rec_kind;
    logic klv = 0, et = 0, known = 0, rec_ready = 1, stall = 0, start = 0, slow = 0;
    logic [3:0] pkts = 4'h0, len = 4'h0;
    int fails = 0, compares = 0, cyc = 0;
    logic [34:0] got[$];
    always #50 aclk = ~aclk;
    // sink stalls two cycles in three when asked, and logs what it takes
    always @(posedge aclk) begin
        cyc++;
        rec_ready <= !stall || (cyc % 3 == 0);
        if (rec_valid && rec_ready) got.push_back({rec_kind, rec_data});
    end
    mvp_packetizer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_data(enc_data),
        .enc_valid(enc_valid), .enc_last(enc_last), .enc_ready(enc_ready), .enc_klv(klv),
        .enc_embedded_time(et), .enc_count_known(known), .rec_data(rec_data),
        .rec_kind(rec_kind), .rec_valid(rec_valid), .rec_ready(rec_ready));
    mvp_enc_model enc (.aclk(aclk), .aresetn(aresetn), .start(start), .pkts(pkts), .len(len),
        .slow(slow), .enc_data(enc_data), .enc_valid(enc_valid), .enc_last(enc_last),
        .enc_ready(enc_ready));
    task automatic chk(input string what, input logic [34:0] seen, input logic [34:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ****
    // bus cycles: address and data together, each dropped once taken
    // ****
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no local limit: only the watchdog ends a wait
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // run np packets of nl words and compare every recorded word
    task automatic frame(input int np, input int nl, input logic st, input logic [31:0] cw,
        input logic ab);
        int k = 2;
        got.delete();
        @(posedge aclk);
        pkts <= np[3:0];
        len <= nl[3:0];
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        // a hang is the watchdog's; the short wait lets a stray extra word show up
        while (got.size() < np * (nl + 2 * st) + 2) @(posedge aclk);
        repeat (8) @(posedge aclk);
        chk("header", got[0], {KIND_HDR, 32'h0});
        chk("channel word", got[1], {KIND_CW, cw});
        for (int p = 0; p < np; p++) begin
            if (st) begin
                if (ab) chk("stamp low", got[k], {KIND_TS, 32'h0000_0100});
                else chk("stamp low", {got[k][34:32], 32'h0}, {KIND_TS, 32'h0});
                if (ab) chk("stamp high", got[k + 1], {KIND_TS, 32'h9abc_def0});
                else chk("stamp high", {got[k + 1][34:16], 16'h0}, {KIND_TS, 32'h0});
                k += 2;
            end
            for (int w = 0; w < nl; w++) begin
                h = (w == 0) ? 32'h4700_0000 : {16'h0da7, 12'h0, w[3:0]};
                chk("data", got[k], {KIND_DATA, h});
                k++;
            end
        end
        chk("extra words", got.size(), k);
    endtask
    task automatic t_regs();
        rd(ADDR_CTRL);
        chk("ctrl reset", d, CTRL_RESET);
        wr(8'h30, 32'h1);
        chk("unmapped write", r, 2'h2);
        rd(8'h30);
        chk("unmapped read", {r, d}, {2'h2, 32'h0});
        wr(ADDR_STATUS, 32'h1);
        chk("read-only write", r, 2'h2);
        $display("test regs done");
    endtask
    task automatic t_plain();
        klv <= 1'b1;
        known <= 1'b1;
        stall <= 1'b1;
        wr(ADDR_CONFIG, 32'h0002_003f);
        wr(ADDR_CTRL, 32'h1);
        frame(2, 3, 0, {10'h0, 3'b100, 4'hb, 3'b011, 12'h2}, 0);
        rd(ADDR_LAST_CW);
        chk("last channel word", d, {10'h0, 3'b100, 4'hb, 3'b011, 12'h2});
        rd(ADDR_STATUS);
        chk("packet count", d, 32'h2);
        stall <= 1'b0;
        $display("test plain done");
    endtask
    task automatic t_stamp();
        klv <= 1'b0;
        et <= 1'b1;
        known <= 1'b0;
        slow <= 1'b1;
        wr(ADDR_CONFIG, 32'h0001_0005);
        wr(ADDR_CTRL, 32'h7);
        frame(1, 4, 1, {10'h0, 3'b011, 4'h5, 3'b100, 12'h0}, 0);
        slow <= 1'b0;
        $display("test stamp done");
    endtask
    task automatic t_abs();
        et <= 1'b0;
        known <= 1'b1;
        wr(ADDR_ABS_LO, 32'h0000_0100);
        wr(ADDR_ABS_HI, 32'h9abc_def0);
        wr(ADDR_CONFIG, 32'h0002_0020);
        wr(ADDR_CTRL, 32'h43);
        frame(2, 2, 1, {10'h0, 3'b001, 4'h0, 3'b001, 12'h2}, 1);
        $display("test abs done");
    endtask
    task automatic t_scr();
        logic [31:0] b;
        wr(ADDR_CTRL, 32'h4);
        rd(ADDR_SCR_HI);
        chk("ext range", d[31:23] < EXT_MOD, 1'b1);
        rd(ADDR_SCR_LO);
        b = d;
        repeat (3000) @(posedge aclk);
        rd(ADDR_SCR_LO);
        // some 3004 cycles apart; a reader's 300 x 10/27 scaling of 27 steps gives them back
        chk("base steps", (d - b) inside {[26:28]}, 1'b1);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_SCR_LO);
        chk("scr cleared", d, 32'h0);
        // the free-running count a reader rebuilds past a rollover is 48 bits
        rd(ADDR_RTC_HI);
        chk("rtc high", d[31:16], 16'h0);
        $display("test scr done");
    endtask
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // whole run needs some 3200 cycles
    initial begin
        #(30_000 * 100);
        fails++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_plain();
        t_stamp();
        t_abs();
        t_scr();
        give_verdict();
    end
endmodule // mvp_packetizer_bench
`default_nettype wire
